/* design/wdt_pkg.sv */
// How it works
// - The unlock port is write-only and stores no readable bits of its own.
// - The reload bytes open for change only after the unlock port is written with 55h and then aah.
// - Writes to the unlock port only step the lock sequencer and store nothing at that address.
// - A read at the unlock port location returns the read-only reset cause register.
// - The upper, middle and low reload bytes form one 24-bit reload value at bits 23:16, 15:8 and 7:0.
// - Each refresh instruction while the count is above 000002h copies the stored 24-bit reload value into the downcounter.
// - A read of a reload byte address returns that byte of the live downcounter, not the stored byte.
// - A permitted write to a reload byte address updates that byte of the stored reload value.
// - After unlock the bytes go upper, middle, low with no other write between; any other write relocks.
// - The downcounter signals a time-out when its count reaches 000000h.
// - Refresh instructions are ignored once the count is 000002h or lower.
// - The stored reload value is loaded into the downcounter when the watchdog is first enabled.
package wdt_pkg;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_UNLOCK     = 12'hff0;
  localparam logic [11:0] IDX_UPPER      = 12'hff1;
  localparam logic [11:0] IDX_MIDDLE     = 12'hff2;
  localparam logic [11:0] IDX_LOW        = 12'hff3;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'hff4;
  localparam logic [11:0] IDX_IRQ_MASK   = 12'hff5;
  localparam logic [11:0] IDX_CONTROL    = 12'hff6;
  localparam int          IDX_W          = 12;
  localparam int          ADDR_W_MIN     = IDX_W + 2;

  // Unlock keys
  localparam logic [7:0] UNLOCK_KEY_FIRST  = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'haa;

  // Reload reset values
  localparam logic [7:0] RST_UPPER  = 8'h00;
  localparam logic [7:0] RST_MIDDLE = 8'h04;
  localparam logic [7:0] RST_LOW    = 8'h00;

  // Counter thresholds
  localparam int          COUNT_W       = 24;
  localparam logic [23:0] REFRESH_FLOOR = 24'h000002;
  localparam logic [23:0] COUNT_ONE     = 24'h000001;
  localparam logic [23:0] MIN_RELOAD    = 24'h000004;

  // Field positions
  localparam int IRQ_W            = 2;
  localparam int STAT_TIMEOUT_BIT = 0;
  localparam int STAT_ABORT_BIT   = 1;
  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int CAUSE_WDT_BIT    = 0;

  // Watchdog oscillator tick derived from the bus clock
  localparam int OSC_PERIOD_NS = 100000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_CYCLES   = OSC_PERIOD_NS / CLK_PERIOD_NS;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic             valid;
    logic [IDX_W-1:0] index;
    logic [7:0]       data;
  } reg_write_s;

  typedef struct packed {
    logic upper;
    logic middle;
    logic low;
  } reload_grant_s;
endpackage

/* design/wdt_unlock_seq.sv */
`timescale 1ns/1ps
module wdt_unlock_seq (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire wdt_pkg::reg_write_s   wr_ev,
  output wdt_pkg::reload_grant_s     grant,
  output logic                       abort
);
  import wdt_pkg::*;

  typedef enum logic [2:0] {LOCKED, GOT_FIRST, OPEN_UPPER, OPEN_MIDDLE, OPEN_LOW} lock_state_e;

  lock_state_e state_q;
  lock_state_e state_d;

  // Next state; every register write moves the sequencer
  always_comb begin
    state_d      = state_q;
    grant        = '0;
    abort        = 1'b0;
    if (wr_ev.valid) begin
      state_d = LOCKED;
      case (state_q)
        LOCKED: begin
          if (wr_ev.index == IDX_UNLOCK && wr_ev.data == UNLOCK_KEY_FIRST) begin
            state_d = GOT_FIRST;
          end
        end
        GOT_FIRST: begin
          if (wr_ev.index == IDX_UNLOCK && wr_ev.data == UNLOCK_KEY_SECOND) begin
            state_d = OPEN_UPPER;
          end else begin
            abort = 1'b1;
          end
        end
        OPEN_UPPER: begin
          if (wr_ev.index == IDX_UPPER) begin
            grant.upper = 1'b1;
            state_d     = OPEN_MIDDLE;
          end else begin
            abort = 1'b1;
          end
        end
        OPEN_MIDDLE: begin
          if (wr_ev.index == IDX_MIDDLE) begin
            grant.middle = 1'b1;
            state_d      = OPEN_LOW;
          end else begin
            abort = 1'b1;
          end
        end
        OPEN_LOW: begin
          // Low byte closes the window again
          if (wr_ev.index == IDX_LOW) begin
            grant.low = 1'b1;
          end else begin
            abort = 1'b1;
          end
        end
        default: state_d = LOCKED;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= LOCKED;
    end else begin
      state_q <= state_d;
    end
  end
endmodule // wdt_unlock_seq

/* design/wdt_downcount.sv */
`timescale 1ns/1ps
module wdt_downcount #(
  parameter int COUNT_W = wdt_pkg::COUNT_W
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               tick,
  input  wire logic               enable,
  input  wire logic               refresh,
  input  wire logic [COUNT_W-1:0] reload,
  output logic      [COUNT_W-1:0] count_q,
  output logic                    running_q,
  output logic                    timeout_q
);
  import wdt_pkg::*;

  if (COUNT_W != 24) begin : g_check
    $error("wdt_downcount supports a 24-bit count only");
  end

  logic start;
  logic refresh_ok;

  // A refresh also enables; late refreshes near zero are dropped
  assign start      = (enable | refresh) & ~running_q;
  assign refresh_ok = refresh & running_q & (count_q > REFRESH_FLOOR);

  // Running flag never clears except by reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      running_q <= 1'b0;
    end else if (start) begin
      running_q <= 1'b1;
    end
  end

  // Count; loads win over a tick in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= {RST_UPPER, RST_MIDDLE, RST_LOW};
    end else if (start) begin
      count_q <= reload;
    end else if (refresh_ok) begin
      count_q <= reload;
    end else if (tick && running_q) begin
      count_q <= count_q - COUNT_ONE;                             // Wraps to all ones after zero
    end
  end

  // One-cycle pulse as the count lands on zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timeout_q <= 1'b0;
    end else begin
      timeout_q <= tick & running_q & ~start & ~refresh_ok & (count_q == COUNT_ONE);
    end
  end
endmodule // wdt_downcount

/* design/wdt_reload_regs.sv */
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
module wdt_reload_regs #(
  parameter int ADDR_W      = wdt_pkg::ADDR_W_MIN,
  parameter int TICK_CYCLES = wdt_pkg::TICK_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              refresh_strobe,
  output logic                   watchdog_timeout,
  output logic                   irq
);
  import wdt_pkg::*;

  if (ADDR_W < ADDR_W_MIN || TICK_CYCLES < 2) begin : g_check
    $error("wdt_reload_regs: address too narrow or tick count too small");
  end

  localparam int TICK_W = $clog2(TICK_CYCLES);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  // Index of a word address; an address beyond the index field maps nowhere
  function automatic logic [IDX_W-1:0] addr_index(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] shifted;
    shifted = addr >> 2;
    if (ADDR_W > ADDR_W_MIN && (addr >> ADDR_W_MIN) != '0) begin
      addr_index = '0;
    end else begin
      addr_index = shifted[IDX_W-1:0];
    end
  endfunction

  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    is_mapped = (idx >= IDX_UNLOCK) && (idx <= IDX_CONTROL);
  endfunction

  logic              aw_held_q;
  logic              w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0]        wbyte_q;
  logic              wlane_q;
  logic              aw_fire;
  logic              w_fire;
  logic              ar_fire;
  logic              wr_commit;
  logic [IDX_W-1:0]  wr_idx;
  logic [IDX_W-1:0]  rd_idx;
  logic [31:0]       rd_mux;
  logic [7:0]        upper_q;
  logic [7:0]        middle_q;
  logic [7:0]        low_q;
  logic [IRQ_W-1:0]  irq_status_q;
  logic [IRQ_W-1:0]  irq_mask_q;
  logic              enable_q;
  logic              cause_wdt_q;
  logic [TICK_W-1:0] tick_cnt_q;
  logic              tick_q;
  logic [COUNT_W-1:0] count;
  logic              running;
  logic              timeout;
  logic              abort;
  reg_write_s        wr_ev;
  reload_grant_s     grant;

  assign aw_fire   = s_axi_awvalid & s_axi_awready;
  assign w_fire    = s_axi_wvalid & s_axi_wready;
  assign ar_fire   = s_axi_arvalid & s_axi_arready;
  assign wr_commit = aw_held_q & w_held_q & ~s_axi_bvalid;
  assign wr_idx    = addr_index(awaddr_q);
  assign rd_idx    = addr_index(s_axi_araddr);

  // Every committed write reaches the sequencer; an unstrobed low lane carries no key
  assign wr_ev.valid = wr_commit;
  assign wr_ev.index = wr_idx;
  assign wr_ev.data  = wlane_q ? wbyte_q : 8'h00;

  // Write address channel; one write in flight at a time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      aw_held_q     <= 1'b0;
      awaddr_q      <= '0;
    end else if (aw_fire) begin
      s_axi_awready <= 1'b0;
      aw_held_q     <= 1'b1;
      awaddr_q      <= s_axi_awaddr;
    end else if (wr_commit) begin
      aw_held_q <= 1'b0;
    end else if (!aw_held_q && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel; only byte lane 0 carries register data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_wready <= 1'b0;
      w_held_q     <= 1'b0;
      wbyte_q      <= 8'h00;
      wlane_q      <= 1'b0;
    end else if (w_fire) begin
      s_axi_wready <= 1'b0;
      w_held_q     <= 1'b1;
      wbyte_q      <= s_axi_wdata[7:0];
      wlane_q      <= s_axi_wstrb[0];
    end else if (wr_commit) begin
      w_held_q <= 1'b0;
    end else if (!w_held_q && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response after both halves are in
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= is_mapped(wr_idx) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Reload bytes change only when the sequencer grants that byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upper_q  <= RST_UPPER;
      middle_q <= RST_MIDDLE;
      low_q    <= RST_LOW;
    end else if (wlane_q) begin
      if (grant.upper) begin
        upper_q <= wbyte_q;
      end
      if (grant.middle) begin
        middle_q <= wbyte_q;
      end
      if (grant.low) begin
        low_q <= wbyte_q;
      end
    end
  end

  // Mask and enable; enable stays set until reset, as a watchdog should
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_mask_q <= '0;
      enable_q   <= 1'b0;
    end else if (wr_commit && wlane_q) begin
      if (wr_idx == IDX_IRQ_MASK) begin
        irq_mask_q <= wbyte_q[IRQ_W-1:0];
      end else if (wr_idx == IDX_CONTROL && wbyte_q[CTRL_ENABLE_BIT]) begin
        enable_q <= 1'b1;
      end
    end
  end

  // Sticky events; a read clears them, but a new event in that cycle wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_status_q <= '0;
    end else begin
      if (ar_fire && rd_idx == IDX_IRQ_STATUS) begin
        irq_status_q <= '0;
      end
      if (timeout) begin
        irq_status_q[STAT_TIMEOUT_BIT] <= 1'b1;
      end
      if (abort) begin
        irq_status_q[STAT_ABORT_BIT] <= 1'b1;
      end
    end
  end

  // Reset cause flag behind the unlock port address, cleared by reading it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cause_wdt_q <= 1'b0;
    end else if (timeout) begin
      cause_wdt_q <= 1'b1;
    end else if (ar_fire && rd_idx == IDX_UNLOCK) begin
      cause_wdt_q <= 1'b0;
    end
  end

  // Read mux; the unlock port itself has nothing to return
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (rd_idx == IDX_UNLOCK) begin
      rd_mux[CAUSE_WDT_BIT] = cause_wdt_q;
    end else if (rd_idx == IDX_UPPER) begin
      rd_mux[7:0] = count[23:16];
    end else if (rd_idx == IDX_MIDDLE) begin
      rd_mux[7:0] = count[15:8];
    end else if (rd_idx == IDX_LOW) begin
      rd_mux[7:0] = count[7:0];
    end else if (rd_idx == IDX_IRQ_STATUS) begin
      rd_mux[IRQ_W-1:0] = irq_status_q;
    end else if (rd_idx == IDX_IRQ_MASK) begin
      rd_mux[IRQ_W-1:0] = irq_mask_q;
    end else if (rd_idx == IDX_CONTROL) begin
      rd_mux[CTRL_ENABLE_BIT] = enable_q;
    end
  end

  // Read channel; answer one cycle after the address is taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= is_mapped(rd_idx) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Stand-in for the slow oscillator: one tick every TICK_CYCLES clocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == TICK_LAST) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q     <= 1'b0;
    end
  end

  // Outputs straight from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq              <= 1'b0;
      watchdog_timeout <= 1'b0;
    end else begin
      irq              <= |(irq_status_q & irq_mask_q);
      watchdog_timeout <= timeout;
    end
  end

  wdt_unlock_seq u_unlock (
    .clk   (clk),
    .rst   (rst),
    .wr_ev (wr_ev),
    .grant (grant),
    .abort (abort)
  );

  wdt_downcount #(
    .COUNT_W (COUNT_W)
  ) u_count (
    .clk       (clk),
    .rst       (rst),
    .tick      (tick_q),
    .enable    (enable_q),
    .refresh   (refresh_strobe),
    .reload    ({upper_q, middle_q, low_q}),
    .count_q   (count),
    .running_q (running),
    .timeout_q (timeout)
  );

  // Running is visible only through the live count, and through the enable bit when enable started it
  logic unused_running;
  assign unused_running = running;
endmodule // wdt_reload_regs

/* test/wdt_reload_regs_props.sv */
`timescale 1ns/1ps
module wdt_reload_regs_props
  import wdt_pkg::*;
#(
  parameter int ADDR_W = 14
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              watchdog_timeout
);
  logic rd_go;
  logic rd_mapped;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Read handshake and whether it hits one of the seven mapped words; the low two address bits are ignored
  assign rd_go     = s_axi_arvalid && s_axi_arready;
  assign rd_mapped = (s_axi_araddr[ADDR_W-1:2] >= IDX_UNLOCK) && (s_axi_araddr[ADDR_W-1:2] <= IDX_CONTROL);

  AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped early");
  AST_READ_ANSWER: assert property (rd_go |=> s_axi_rvalid) else $error("read answer late");
  AST_READ_BYTE_ONLY: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
  AST_CAUSE_READ: assert property (rd_go && s_axi_araddr == {IDX_UNLOCK, 2'h0}
    |=> s_axi_rresp == RESP_OKAY && s_axi_rdata[7:1] == 7'h0) else $error("unlock port read not reset cause");
  AST_UNMAPPED_READ: assert property (rd_go && !rd_mapped
    |=> s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  AST_BUSY_WRITE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write ready early");
  AST_BUSY_READ: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read ready early");
  AST_TIMEOUT_PULSE: assert property (watchdog_timeout |=> !watchdog_timeout)
    else $error("time-out pulse too long");
endmodule // wdt_reload_regs_props

bind wdt_reload_regs wdt_reload_regs_props #(.ADDR_W(ADDR_W)) props (.clk(clk), .rst(rst),
  .s_axi_araddr(s_axi_araddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .watchdog_timeout(watchdog_timeout));

/* test/refresh_source.sv */
`timescale 1ns/1ps
module refresh_source (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       req,
  input wire logic [3:0] gap,
  output logic           refresh_strobe
);
  logic [4:0] wait_q;

  // Instruction issue, gap plus one cycles after the request; slow gaps mimic a busy pipeline
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q         <= 5'h0;
      refresh_strobe <= 1'b0;
    end else begin
      refresh_strobe <= (wait_q == 5'h1); // One pulse per refresh instruction
      if (req) begin
        wait_q <= {1'b0, gap} + 5'h1;
      end else if (wait_q != 5'h0) begin
        wait_q <= wait_q - 5'h1;
      end
    end
  end
endmodule // refresh_source

/* test/test_watchdog_reload_register_access.sv */
`timescale 1ns/1ps
module test_watchdog_reload_register_access;
  import wdt_pkg::*;
  logic [13:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, strobe, timeout, irq, ref_req;
  logic [3:0]  ref_gap;
  logic [7:0]  up, mid;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          fails, checks_done, cyc, n;

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  wdt_reload_regs #(.ADDR_W(14), .TICK_CYCLES(16)) dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .refresh_strobe(strobe), .watchdog_timeout(timeout), .irq(irq));
  refresh_source src (.clk(clk), .rst(rst), .req(ref_req), .gap(ref_gap), .refresh_strobe(strobe));

  task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    bq.push_back(RESP_OKAY);
    awaddr  <= {idx, 2'h0};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    @(posedge clk); // An edge between transfers, so bready is never set twice in one step
  endtask

  // Read: the expected word is queued for the monitor
  task automatic rd(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    rq.push_back({er, 24'h0, d});
    araddr  <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    @(posedge clk); // An edge between transfers, so rready is never set twice in one step
  endtask

  task automatic refresh(input logic [3:0] g);
    ref_gap <= g;
    ref_req <= 1'b1;
    @(posedge clk);
    ref_req <= 1'b0;
    repeat (g + 6) @(posedge clk);
  endtask

  task automatic unlock();
    wr(IDX_UNLOCK, UNLOCK_KEY_FIRST);
    wr(IDX_UNLOCK, UNLOCK_KEY_SECOND);
  endtask

  // Monitor takes the oldest note whenever a response is handed over
  always @(posedge clk) begin
    if (rvalid && rready) chk("read", {rresp, rdata}, rq.pop_front());
    if (bvalid && bready) chk("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
  end

  // Hang guard; the whole run needs a few hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready, ref_req, ref_gap} = '0;
    {fails, checks_done, cyc} = '0;
    rst = 1'b1;
    void'($urandom(90));
    up  = 8'($urandom) | 8'h01;
    mid = 8'($urandom);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(IDX_UPPER, RST_UPPER);
    rd(IDX_MIDDLE, RST_MIDDLE);
    rd(IDX_LOW, RST_LOW);
    rd(IDX_UNLOCK, 8'h00);
    rd(12'hffc, 8'h00, RESP_DECERR);
    wr(IDX_IRQ_MASK, 8'h03);
    rd(IDX_IRQ_MASK, 8'h03);
    wr(IDX_UPPER, 8'h33);
    // Out-of-order byte breaks the sequence and raises the abort event
    unlock();
    wr(IDX_UPPER, 8'h5a);
    wr(IDX_LOW, 8'h11);
    repeat (2) @(posedge clk);
    chk("irq", {33'h0, irq}, 34'h1);
    rd(IDX_IRQ_STATUS, 8'h02);
    @(posedge clk);
    chk("irq", {33'h0, irq}, 34'h0);
    rd(IDX_UNLOCK, 8'h00);
    wr(IDX_MIDDLE, 8'h99);
    unlock();
    wr(IDX_UPPER, up);
    wr(IDX_MIDDLE, mid);
    wr(IDX_LOW, 8'h80);
    wr(IDX_UPPER, 8'h00);
    refresh(4'h9);
    rd(IDX_UPPER, up);
    rd(IDX_MIDDLE, mid);
    // Smallest legal reload, then a refresh that arrives too late
    unlock();
    wr(IDX_UPPER, 8'h00);
    wr(IDX_MIDDLE, 8'h00);
    wr(IDX_LOW, MIN_RELOAD[7:0]);
    refresh(4'h0);
    n = 0;
    while (!timeout && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("timeout", {33'h0, timeout}, 34'h1);
    refresh(4'h0);
    repeat (20) @(posedge clk);
    rd(IDX_UPPER, 8'hff);
    chk("irq", {33'h0, irq}, 34'h1);
    rd(IDX_IRQ_STATUS, 8'h01);
    rd(IDX_UNLOCK, 8'h01);
    rd(IDX_UNLOCK, 8'h00);
    // Reset in the middle of an open sequence must close it
    unlock();
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wr(IDX_UPPER, 8'h77);
    // Start by the enable bit alone; one or two ticks take the middle byte down by one
    wr(IDX_CONTROL, 8'h01);
    repeat (20) @(posedge clk);
    rd(IDX_MIDDLE, RST_MIDDLE - 8'h01);
    rd(IDX_CONTROL, 8'h01);
    refresh(4'h0);
    rd(IDX_UPPER, RST_UPPER);
    complete_run();
  end
endmodule // test_watchdog_reload_register_access
